// file: flash_cmd_pkg.sv
// Opcodes, encodings and timing for the serial flash command interpreter
package flash_cmd_pkg;
	localparam logic [7:0] OP_WSR      = 8'h01;
	localparam logic [7:0] OP_PROG     = 8'h02;
	localparam logic [7:0] OP_QPROG    = 8'h32;
	localparam logic [7:0] OP_SECPROG  = 8'h42;
	localparam logic [7:0] OP_SECTOR   = 8'h20;
	localparam logic [7:0] OP_BLK32    = 8'h52;
	localparam logic [7:0] OP_BLK64    = 8'hd8;
	localparam logic [7:0] OP_CHIP_A   = 8'hc7;
	localparam logic [7:0] OP_CHIP_B   = 8'h60;
	localparam logic [7:0] OP_SECERASE = 8'h44;
	localparam logic [7:0] OP_RDSR1    = 8'h05;
	localparam logic [7:0] OP_RDSR2    = 8'h35;
	localparam logic [7:0] OP_SUSPEND  = 8'h75;
	localparam logic [7:0] OP_RESUME   = 8'h7a;
	localparam logic [7:0] OP_PWRDOWN  = 8'hb9;
	localparam logic [7:0] OP_RELEASE  = 8'hab;
	localparam logic [7:0] OP_ID1      = 8'h90;
	localparam logic [7:0] OP_ID2      = 8'h92;
	localparam logic [7:0] OP_ID4      = 8'h94;
	// Rising edges before output starts
	localparam logic [7:0] BITS_OPCODE = 8'd8;
	localparam logic [7:0] HDR_ID      = 8'd32;
	localparam logic [7:0] HDR_DUAL    = 8'd24;
	localparam logic [7:0] HDR_QUAD    = 8'd20;
	localparam logic [7:0] CNT_MAX     = 8'hff;
	// Timing in ns and in 25 ns cycles
	localparam int CLK_NS      = 25;
	localparam int T_SUS_NS    = 20000;
	localparam int T_RESUME_NS = 200;
	localparam int T_DP_NS     = 3000;
	localparam int T_RES1_NS   = 3000;
	localparam int T_RES2_NS   = 1800;
	localparam int SUS_CYC     = T_SUS_NS / CLK_NS;
	localparam int RESUME_CYC  = T_RESUME_NS / CLK_NS;
	localparam int DP_CYC      = T_DP_NS / CLK_NS;
	localparam int RES1_CYC    = (T_RES1_NS + CLK_NS - 1) / CLK_NS;
	localparam int RES2_CYC    = (T_RES2_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [9:0] WAIT_ONE = 10'h001;
	typedef enum logic [1:0] {PWR_ON = 2'b00, PWR_ENTER = 2'b01, PWR_DOWN = 2'b10, PWR_WAKE = 2'b11} pwr_e;
	typedef enum logic [2:0] {K_NONE = 3'b000, K_ERASE = 3'b001, K_CHIP = 3'b010, K_PROG = 3'b011,
		K_WSR = 3'b100} kind_e;
	typedef enum logic [1:0] {L1 = 2'b00, L2 = 2'b01, L4 = 2'b10} lane_e;

	// Class of array work an opcode starts
	function automatic kind_e opKind(input logic [7:0] op);
		case (op)
			OP_SECTOR, OP_BLK32, OP_BLK64, OP_SECERASE: opKind = K_ERASE;
			OP_CHIP_A, OP_CHIP_B: opKind = K_CHIP;
			OP_PROG, OP_QPROG, OP_SECPROG: opKind = K_PROG;
			OP_WSR: opKind = K_WSR;
			default: opKind = K_NONE;
		endcase
	endfunction : opKind
endpackage : flash_cmd_pkg

// file: flash_cmd_ctrl.sv
// Command interpreter for suspend, resume, power-down and identification
`timescale 1ns/10ps
module flash_cmd_ctrl
	import flash_cmd_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART_ID  = 8'h3c  // Arbitrary value
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Serial link pins
	input  wire logic       csB,
	input  wire logic       sclk,
	input  wire logic [3:0] ioIn,
	output logic      [3:0] ioOut,
	output logic      [3:0] ioOe,
	// Array engine
	output logic            arrayStart,
	output logic      [7:0] arrayOpcode,
	output logic            arrayHold,
	input  wire logic       arrayDone,
	// Status
	output logic            busy,
	output logic            suspendFlag,
	output logic            powerDown
);
	localparam int SusBound = SUS_CYC;
	localparam int ResBound = RESUME_CYC;
	localparam int DpBound  = DP_CYC + 1;

	logic [1:0]  csSync;
	logic [1:0]  clkSync;
	logic [3:0]  ioMeta;
	logic [3:0]  ioSync;
	logic        csPrev;
	logic        clkPrev;
	logic [7:0]  riseCnt;
	logic [7:0]  opShift;
	logic        halting;
	logic [9:0]  haltCnt;
	kind_e       curKind;
	kind_e       suspKind;
	pwr_e        pwrState;
	logic [9:0]  waitCnt;
	logic [15:0] outShift;
	logic        outOn;
	lane_e       outLanes;

	// Two-stage synchronisers for every pin
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			csSync <= 2'b11;
			clkSync <= 2'b00;
			ioMeta <= 4'h0;
			ioSync <= 4'h0;
			csPrev <= 1'b1;
			clkPrev <= 1'b0;
		end else begin
			csSync <= {csSync[0], csB};
			clkSync <= {clkSync[0], sclk};
			ioMeta <= ioIn;
			ioSync <= ioMeta;
			csPrev <= csSync[1];
			clkPrev <= clkSync[1];
		end
	end

	// Edge detection on the synchronised pins
	logic sRise;
	logic sFall;
	logic csLow;
	logic csRise;
	assign sRise = clkSync[1] & ~clkPrev;
	assign sFall = ~clkSync[1] & clkPrev;
	assign csLow = ~csSync[1];
	assign csRise = csSync[1] & ~csPrev;

	// Opcode shift and rising edge count per frame
	always_ff @(posedge clk) begin
		if (!rst_b || !csLow) begin
			riseCnt <= 8'h00;
			opShift <= 8'h00;
		end else if (sRise) begin
			if (riseCnt != CNT_MAX) begin
				riseCnt <= riseCnt + 8'h01;
			end
			if (riseCnt < BITS_OPCODE) begin
				opShift <= {opShift[6:0], ioSync[0]};
			end
		end
	end

	// Decode of the received opcode against device state
	logic  opDone8;
	kind_e kindNow;
	logic  statusOp;
	logic  heard;
	logic  blockedBySusp;
	logic  suspOk;
	logic  resOk;
	logic  startOk;
	logic  pdOk;
	logic  relOk;
	assign opDone8 = riseCnt >= BITS_OPCODE;
	assign kindNow = opKind(opShift);
	assign statusOp = (opShift == OP_RDSR1) || (opShift == OP_RDSR2);
	assign heard = (pwrState == PWR_ON) || (pwrState == PWR_DOWN && opShift == OP_RELEASE);
	assign blockedBySusp = suspendFlag && ((kindNow == K_WSR) ||
		(suspKind == K_ERASE && (kindNow == K_ERASE || kindNow == K_CHIP)) ||
		(suspKind == K_PROG && kindNow == K_PROG));
	assign suspOk = csRise && opDone8 && heard && opShift == OP_SUSPEND && !suspendFlag && busy && !halting &&
		(curKind == K_ERASE || curKind == K_PROG);
	assign resOk = csRise && opDone8 && heard && opShift == OP_RESUME && suspendFlag && !busy;
	assign startOk = csRise && opDone8 && heard && !busy && kindNow != K_NONE && !blockedBySusp;
	assign pdOk = csRise && riseCnt == BITS_OPCODE && heard && !busy && opShift == OP_PWRDOWN;
	assign relOk = csRise && opDone8 && heard && !busy && pwrState == PWR_DOWN;

	// Array operation, suspend and resume tracking
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy <= 1'b0;
			suspendFlag <= 1'b0;
			halting <= 1'b0;
			haltCnt <= 10'h000;
			curKind <= K_NONE;
			suspKind <= K_NONE;
			arrayStart <= 1'b0;
			arrayOpcode <= 8'h00;
		end else begin
			arrayStart <= startOk;
			if (startOk) begin
				busy <= 1'b1;
				curKind <= kindNow;
				arrayOpcode <= opShift;
			end else if (suspOk) begin
				suspendFlag <= 1'b1;
				halting <= 1'b1;
				haltCnt <= 10'(SUS_CYC);
				suspKind <= curKind;
			end else if (halting) begin
				haltCnt <= haltCnt - WAIT_ONE;
				if (haltCnt == WAIT_ONE) begin
					halting <= 1'b0;
					busy <= 1'b0;
					curKind <= K_NONE;
				end
			end else if (resOk) begin
				suspendFlag <= 1'b0;
				busy <= 1'b1;
				curKind <= suspKind;
				suspKind <= K_NONE;
			end else if (arrayDone && busy) begin
				busy <= 1'b0;
				curKind <= K_NONE;
			end
		end
	end

	// Engine freezes the suspended operation while the flag stands
	assign arrayHold = suspendFlag;

	// Power state machine
	logic waitEnd;
	assign waitEnd = waitCnt == WAIT_ONE;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pwrState <= PWR_ON;
			waitCnt <= 10'h000;
		end else begin
			case (pwrState)
				PWR_ON: begin
					if (pdOk) begin
						pwrState <= PWR_ENTER;
						waitCnt <= 10'(DP_CYC);
					end
				end
				PWR_ENTER: begin
					waitCnt <= waitCnt - WAIT_ONE;
					if (waitEnd) begin
						pwrState <= PWR_DOWN;
					end
				end
				PWR_DOWN: begin
					if (relOk) begin
						pwrState <= PWR_WAKE;
						waitCnt <= (riseCnt >= HDR_ID) ? 10'(RES2_CYC) : 10'(RES1_CYC);
					end
				end
				PWR_WAKE: begin
					waitCnt <= waitCnt - WAIT_ONE;
					if (waitEnd) begin
						pwrState <= PWR_ON;
					end
				end
				default: begin
					pwrState <= PWR_ON;
				end
			endcase
		end
	end
	assign powerDown = pwrState == PWR_DOWN;

	// Readout selection: word, lanes and header length
	logic        readOp;
	logic [7:0]  srByte;
	logic [15:0] outWord;
	lane_e       laneNow;
	logic [7:0]  hdrLen;
	logic        readGo;
	assign readOp = statusOp || opShift == OP_RELEASE || opShift == OP_ID1 || opShift == OP_ID2 ||
		opShift == OP_ID4;
	assign srByte = (opShift == OP_RDSR1) ? {7'h00, busy} : {suspendFlag, 7'h00};
	assign outWord = statusOp ? {srByte, srByte} :
		(opShift == OP_RELEASE) ? {PART_ID, PART_ID} : {MAKER_ID, PART_ID};
	assign laneNow = (opShift == OP_ID4) ? L4 : (opShift == OP_ID2) ? L2 : L1;
	assign hdrLen = statusOp ? BITS_OPCODE : (opShift == OP_ID4) ? HDR_QUAD :
		(opShift == OP_ID2) ? HDR_DUAL : HDR_ID;
	assign readGo = readOp && heard && opDone8 && riseCnt >= hdrLen && (!busy || statusOp);

	// Rotate the output word by the active lane count
	function automatic logic [15:0] rotl(input logic [15:0] s, input lane_e l);
		case (l)
			L4: rotl = {s[11:0], s[15:12]};
			L2: rotl = {s[13:0], s[15:14]};
			default: rotl = {s[14:0], s[15]};
		endcase
	endfunction : rotl

	// Output shifter, advanced on falling link clock edges
	always_ff @(posedge clk) begin
		if (!rst_b || !csLow) begin
			outShift <= 16'h0000;
			outOn <= 1'b0;
			outLanes <= L1;
		end else if (sFall && readGo) begin
			outOn <= 1'b1;
			if (!outOn) begin
				outShift <= outWord;
				outLanes <= laneNow;
			end else begin
				outShift <= rotl(outShift, outLanes);
			end
		end
	end

	// Pin drive: single on io1, dual on io1..0, quad on io3..0
	assign ioOut = (outLanes == L4) ? outShift[15:12] :
		(outLanes == L2) ? {2'b00, outShift[15:14]} : {2'b00, outShift[15], 1'b0};
	assign ioOe = !outOn ? 4'h0 : (outLanes == L4) ? 4'hf : (outLanes == L2) ? 4'h3 : 4'h2;

	// Checks on the guarded behaviour
	chk_susp_accept: assert property (@(posedge clk) disable iff (!rst_b)
		(csRise && opDone8 && heard && opShift == OP_SUSPEND && !suspendFlag && busy && !halting &&
		curKind == K_PROG) |=> suspendFlag)
		else $error("suspend during program not taken");
	chk_busy_halt: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(suspendFlag) |-> busy ##[1:SusBound] !busy)
		else $error("busy did not fall within suspend latency");
	chk_chip_nosusp: assert property (@(posedge clk) disable iff (!rst_b)
		(csRise && opShift == OP_SUSPEND && curKind == K_CHIP && !suspendFlag) |=> !suspendFlag)
		else $error("chip erase was suspended");
	chk_erase_refuse: assert property (@(posedge clk) disable iff (!rst_b)
		(csRise && suspendFlag && suspKind == K_ERASE &&
		(kindNow == K_ERASE || kindNow == K_CHIP || kindNow == K_WSR)) |=> !arrayStart)
		else $error("erase or status write started in erase suspend");
	chk_prog_refuse: assert property (@(posedge clk) disable iff (!rst_b)
		(csRise && suspendFlag && suspKind == K_PROG && (kindNow == K_PROG || kindNow == K_WSR))
		|=> !arrayStart)
		else $error("program or status write started in program suspend");
	chk_resume_busy: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(suspendFlag) |-> ##[0:ResBound] busy)
		else $error("busy not raised after resume");
	chk_resume_ignore: assert property (@(posedge clk) disable iff (!rst_b)
		(csRise && opShift == OP_RESUME && !suspendFlag && !busy) |=> !busy)
		else $error("resume without suspend raised busy");
	chk_pd_entry: assert property (@(posedge clk) disable iff (!rst_b)
		pdOk |-> ##[1:DpBound] powerDown)
		else $error("power-down not entered in time");
	chk_pd_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		(powerDown && opShift != OP_RELEASE) |-> (ioOe == 4'h0 && !startOk))
		else $error("command answered in power-down");
	chk_busy_noid: assert property (@(posedge clk) disable iff (!rst_b)
		(busy && opShift == OP_RELEASE) |-> ioOe == 4'h0)
		else $error("release readout while busy");
	chk_wake_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		(pwrState == PWR_WAKE) |-> (!startOk && !pdOk && ioOe == 4'h0))
		else $error("command taken during release delay");
	chk_out_fall: assert property (@(posedge clk) disable iff (!rst_b)
		(ioOe != 4'h0 && $changed(ioOut)) |-> $past(sFall))
		else $error("output changed away from falling edge");
endmodule : flash_cmd_ctrl

// file: spi_host_model.sv
// Host side of the serial link: framing, link clocking and readout capture
`timescale 1ns/10ps
module spi_host_model (
	// Clock
	input  wire logic       clk,
	// Link pins
	output logic            csB,
	output logic            sclk,
	output logic      [3:0] ioIn,
	input  wire logic [3:0] ioOut,
	input  wire logic [3:0] ioOe
);
	// Idle link: deselected, clock parked low
	initial begin
		csB = 1'b1;
		sclk = 1'b0;
		ioIn = 4'h0;
	end

	// One 200 ns link period, data set while the clock is low
	task automatic tick(input logic [3:0] d);
		ioIn <= d;
		repeat (4) @(posedge clk);
		sclk <= 1'b1;
		repeat (4) @(posedge clk);
		sclk <= 1'b0;
	endtask : tick

	// Opcode, nx header periods (all ones on a..a+m-1), nr readout periods of w lanes
	task automatic xfer(input logic [7:0] op, input int nx, input int a, input int m, input int nr, input int w,
		output logic [31:0] rd, output logic [3:0] oe);
		rd = 32'h0;
		oe = 4'h0;
		@(posedge clk);
		csB <= 1'b0;
		for (int i = 7; i >= 0; i--) tick({3'h0, op[i]});
		for (int i = 0; i < nx; i++) tick((i >= a && i < a + m) ? 4'hf : 4'h0);
		for (int i = 0; i < nr; i++) begin
			tick({4{i[0]}});
			oe = ioOe;
			case (w)
				1: rd = {rd[30:0], ioOut[1]};
				2: rd = {rd[29:0], ioOut[1:0]};
				default: rd = {rd[27:0], ioOut};
			endcase
		end
		csB <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : xfer
endmodule : spi_host_model

// file: flash_suspend_powerdown_id_cmds_test.sv
// Self-checking bench for the flash command interpreter
`timescale 1ns/10ps
module flash_suspend_powerdown_id_cmds_test
	import flash_cmd_pkg::*;
;
	localparam logic [7:0] MAKER = 8'ha5; // Arbitrary value
	localparam logic [7:0] PART  = 8'h17; // Arbitrary value
	logic        clk;
	logic        rst_b;
	logic        csB;
	logic        sclk;
	logic  [3:0] ioIn;
	logic  [3:0] ioOut;
	logic  [3:0] ioOe;
	logic        arrayStart;
	logic  [7:0] arrayOpcode;
	logic        arrayHold;
	logic        arrayDone;
	logic        busy;
	logic        suspendFlag;
	logic        powerDown;
	logic  [2:0] stat;
	logic [31:0] rd;
	logic  [3:0] oe;
	int          err_count = 0;
	int          compares = 0;
	int          starts = 0;

	flash_cmd_ctrl #(.MAKER_ID(MAKER), .PART_ID(PART)) flash_cmd_ctrl_i (.clk(clk), .rst_b(rst_b), .csB(csB),
		.sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .arrayStart(arrayStart), .arrayOpcode(arrayOpcode),
		.arrayHold(arrayHold), .arrayDone(arrayDone), .busy(busy), .suspendFlag(suspendFlag), .powerDown(powerDown));
	spi_host_model spi_host_model_i (.clk(clk), .csB(csB), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

	// Status bits: 0 busy, 1 suspend, 2 power-down
	assign stat = {powerDown, suspendFlag, busy};

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Array start counter
	always @(posedge clk) if (arrayStart === 1'b1) starts <= starts + 1;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic waitBit(input int idx, input logic want, input int lim);
		for (int n = 0; n < lim && stat[idx] !== want; n++) @(posedge clk);
	endtask : waitBit

	// Header length of array commands
	function automatic int nxOf(input logic [7:0] op);
		if (op == OP_CHIP_A || op == OP_CHIP_B || op == OP_SUSPEND || op == OP_RESUME) return 0;
		if (op == OP_PWRDOWN || op == OP_RELEASE) return 0;
		if (op == OP_WSR) return 8;
		if (op == OP_PROG || op == OP_QPROG || op == OP_SECPROG) return 32;
		return 24;
	endfunction : nxOf

	task automatic cmd(input logic [7:0] op);
		spi_host_model_i.xfer(op, nxOf(op), 0, 0, 0, 1, rd, oe);
	endtask : cmd

	task automatic doReset;
		rst_b <= 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : doReset

	// Engine reports completion
	task automatic done;
		arrayDone <= 1'b1;
		@(posedge clk);
		arrayDone <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : done

	task automatic suspendOk;
		cmd(OP_SUSPEND);
		chk("suspendFlag", 1, suspendFlag);
		chk("arrayHold", 1, arrayHold);
		waitBit(0, 1'b0, SUS_CYC + 8);
		chk("busy", 0, busy);
	endtask : suspendOk

	task automatic t_reset;
		chk("status", 0, stat);
		chk("ioOe", 0, ioOe);
	endtask : t_reset

	// Identification readout in every lane width
	task automatic t_ids;
		spi_host_model_i.xfer(OP_RELEASE, 24, 0, 0, 16, 1, rd, oe);
		chk("part id", {PART, PART}, rd);
		chk("ioOe", 4'h2, oe);
		repeat (RES2_CYC) @(posedge clk);
		spi_host_model_i.xfer(OP_ID1, 24, 0, 0, 32, 1, rd, oe);
		chk("id single", {MAKER, PART, MAKER, PART}, rd);
		spi_host_model_i.xfer(OP_ID2, 16, 12, 2, 16, 2, rd, oe);
		chk("id dual", {MAKER, PART, MAKER, PART}, rd);
		chk("ioOe", 4'h3, oe);
		spi_host_model_i.xfer(OP_ID4, 12, 6, 1, 8, 4, rd, oe);
		chk("id quad", {MAKER, PART, MAKER, PART}, rd);
		chk("ioOe", 4'hf, oe);
	endtask : t_ids

	// Erase suspend, refusals, work in between, resume
	task automatic t_erase;
		logic [7:0] bad [7] = '{OP_WSR, OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP_A, OP_CHIP_B, OP_SECERASE};
		int s;
		cmd(OP_SECTOR);
		chk("busy", 1, busy);
		suspendOk;
		s = starts;
		foreach (bad[i]) cmd(bad[i]);
		chk("refused starts", s, starts);
		cmd(OP_PROG);
		chk("program starts", s + 1, starts);
		chk("arrayOpcode", OP_PROG, arrayOpcode);
		done;
		cmd(OP_RESUME);
		chk("suspendFlag", 0, suspendFlag);
		chk("arrayHold", 0, arrayHold);
		waitBit(0, 1'b1, RESUME_CYC);
		chk("busy", 1, busy);
		done;
		cmd(OP_RESUME);
		chk("status", 0, stat);
		repeat (SUS_CYC) @(posedge clk);
		cmd(OP_SUSPEND);
		chk("suspendFlag", 0, suspendFlag);
	endtask : t_erase

	// Program suspend with busy-time release request
	task automatic t_prog;
		logic [7:0] bad [4] = '{OP_WSR, OP_PROG, OP_QPROG, OP_SECPROG};
		int s;
		cmd(OP_PROG);
		spi_host_model_i.xfer(OP_RELEASE, 24, 0, 0, 16, 1, rd, oe);
		chk("ioOe busy", 0, oe);
		chk("busy", 1, busy);
		suspendOk;
		s = starts;
		foreach (bad[i]) cmd(bad[i]);
		chk("refused starts", s, starts);
		cmd(OP_RESUME);
		done;
	endtask : t_prog

	task automatic t_chip;
		cmd(OP_CHIP_A);
		cmd(OP_SUSPEND);
		chk("status", 1, stat);
		done;
	endtask : t_chip

	// Power loss while suspended
	task automatic t_lost;
		cmd(OP_SECTOR);
		suspendOk;
		doReset;
		chk("status", 0, stat);
		cmd(OP_RESUME);
		chk("status", 0, stat);
	endtask : t_lost

	task automatic t_pdown;
		int s;
		spi_host_model_i.xfer(OP_PWRDOWN, 1, 0, 0, 0, 1, rd, oe);
		waitBit(2, 1'b1, DP_CYC + 10);
		chk("powerDown long", 0, powerDown);
		cmd(OP_PWRDOWN);
		waitBit(2, 1'b1, DP_CYC + 10);
		chk("powerDown", 1, powerDown);
		s = starts;
		spi_host_model_i.xfer(OP_RDSR1, 0, 0, 0, 8, 1, rd, oe);
		chk("ioOe down", 0, oe);
		cmd(OP_SECTOR);
		chk("starts down", s, starts);
		cmd(OP_RELEASE);
		chk("powerDown", 0, powerDown);
		repeat (RES1_CYC) @(posedge clk);
		spi_host_model_i.xfer(OP_RDSR1, 0, 0, 0, 8, 1, rd, oe);
		chk("ioOe awake", 4'h2, oe);
		chk("status byte", 0, rd);
	endtask : t_pdown

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	// Main sequence
	initial begin
		rst_b = 1'b0;
		arrayDone = 1'b0;
		@(posedge clk);
		doReset;
		t_reset;
		t_ids;
		t_erase;
		t_prog;
		t_chip;
		t_lost;
		t_pdown;
		print_verdict;
	end

	// Hang guard
	initial begin
		repeat (80000) @(posedge clk);
		err_count++;
		print_verdict;
	end
endmodule : flash_suspend_powerdown_id_cmds_test
